// *** bench/ccpos_pin_load.sv ***
// pin load model: the switches and loads hanging on the six output pins
`timescale 1ns/1ps
`default_nettype none

module ccpos_pin_load (
  // clock and pins from the block
  input  wire logic       clock,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  // levels seen by the loads
  output var  logic [5:0] pad
);
  logic [5:0] last_q;

  // remembers the last level each pin drove
  always_ff @(posedge clock) begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) begin
        last_q[i] <= pin_out[i];
      end
    end
  end

  // released pins float
  // a released pin has no keeper, so show the inverse of the last level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pad[i] = pin_oe_n[i] ? ~last_q[i] : pin_out[i];
    end
  end
endmodule // ccpos_pin_load

`default_nettype wire

// *** bench/ccpos_top_tb.sv ***
// self-checking testbench for the ccp output shutdown control block
`timescale 1ns/1ps
`default_nettype none

module ccpos_top_tb;
  logic        clock, arst_n, reg_wr, reg_rd, tb_rollover, pwm_raw, mode_aux;
  logic        timer_mode, compare_event, trig_in, fault_input_one;
  logic        aux_out, capture_event, tb_run, shutdown_active_flag, capture_disable_flag;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [6:0]  capsrc;
  logic [2:0]  xsrc;
  logic [5:0]  pin_out, pin_oe_n, pad;
  int          err_count, tests_run, c, g2, g6;

  // ****************************************
  // clock, design and pin loads
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ccpos_top u_dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tb_rollover(tb_rollover),
    .pwm_raw(pwm_raw), .mode_aux(mode_aux), .timer_mode(timer_mode),
    .compare_event(compare_event), .trig_in(trig_in), .comparator_out(capsrc[3:1]),
    .other_compare(xsrc[1:0]), .logic_cell_one(capsrc[5]), .logic_cell_two(capsrc[6]),
    .fault_input_one(fault_input_one), .fault_input_two(xsrc[2]), .capture_pin(capsrc[0]),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .aux_out(aux_out),
    .capture_event(capture_event), .tb_run(tb_run),
    .shutdown_active_flag(shutdown_active_flag),
    .capture_disable_flag(capture_disable_flag));

  ccpos_pin_load u_load (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad(pad));

  // ****************************************
  // bus, pulse and compare helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask

  // one-cycle pulse: 0 rollover, 1 trigger, 2 compare event
  task automatic strobe(input int k);
    @(posedge clock);
    tb_rollover <= (k == 0);
    trig_in <= (k == 1);
    compare_event <= (k == 2);
    @(posedge clock);
    tb_rollover <= 1'b0;
    trig_in <= 1'b0;
    compare_event <= 1'b0;
  endtask

  // counts cycles with aux_out (aux=1) or capture_event (aux=0) high
  task automatic cnt(input int n, input bit aux, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clock);
      k += ((aux ? aux_out : capture_event) === 1'b1);
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("counts run=%0d bad=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [15:0] rv [4] = '{16'h0000, 16'h0100, 16'h0000, 16'h0000};
    logic [15:0] mk [4] = '{16'hD0FF, 16'hBFDF, 16'h003F, 16'hF73F};
    for (int i = 0; i < 4; i++) begin
      rd(3'(i), v);
      chk(v, rv[i]);
      wr(3'(i), 16'hFFFF);
      rd(3'(i), v);
      chk(v, mk[i]);
      wr(3'(i), rv[i]);
    end
    wr(3'h5, 16'hFFFF);
    rd(3'h5, v);
    chk(v, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_steer;
    wr(3'h3, 16'h0020);
    wr(3'h1, 16'h0300);
    pwm_raw <= 1'b1;
    cyc(5);
    chk(16'(pin_oe_n), 16'h003C);
    chk(16'(pad[1:0]), 16'h0002);
    wr(3'h3, 16'h0030);
    cyc(5);
    chk(16'(pad[1:0]), 16'h0000);
    pwm_raw <= 1'b0;
    $display("test steer done");
  endtask

  task automatic t_shut;
    wr(3'h3, 16'h000E);
    wr(3'h0, 16'h0080);
    fault_input_one <= 1'b1;
    cyc(6);
    chk(16'(shutdown_active_flag), 16'h0000);
    wr(3'h0, 16'h0040);
    cyc(5);
    chk(16'(shutdown_active_flag), 16'h0001);
    chk(16'(pad[1:0]), 16'h0001);
    fault_input_one <= 1'b0;
    cyc(5);
    chk(16'(shutdown_active_flag), 16'h0001);
    wr(3'h4, 16'h0000);
    cyc(3);
    chk(16'(shutdown_active_flag), 16'h0000);
    wr(3'h3, 16'h0002);
    wr(3'h0, 16'h1000);
    cyc(4);
    chk(16'(pin_oe_n[1:0]), 16'h0001);
    rd(3'h4, v);
    chk(16'(v[4]), 16'h0001);
    wr(3'h0, 16'h0000);
    wr(3'h4, 16'h0000);
    $display("test shutdown done");
  endtask

  // each of the eight sources alone raises shutdown, then is cleared by software
  task automatic t_src;
    for (int j = 0; j < 8; j++) begin
      wr(3'h0, 16'(1 << j));
      {xsrc[2], fault_input_one, capsrc[5], xsrc[1:0], capsrc[3:1]} <= 8'(1 << j);
      cyc(5);
      chk(16'(shutdown_active_flag), 16'h0001);
      {xsrc[2], fault_input_one, capsrc[5], xsrc[1:0], capsrc[3:1]} <= 8'h00;
      cyc(4);
      wr(3'h4, 16'h0000);
      cyc(3);
      chk(16'(shutdown_active_flag), 16'h0000);
    end
    wr(3'h0, 16'h0000);
    $display("test sources done");
  endtask

  task automatic t_gate;
    wr(3'h0, 16'h5000);
    cyc(6);
    chk(16'(shutdown_active_flag), 16'h0000);
    strobe(0);
    cyc(2);
    chk(16'(shutdown_active_flag), 16'h0001);
    wr(3'h0, 16'h8000);
    cyc(4);
    chk(16'(shutdown_active_flag), 16'h0001);
    strobe(0);
    cyc(2);
    chk(16'(shutdown_active_flag), 16'h0000);
    $display("test gate done");
  endtask

  task automatic t_sync;
    wr(3'h1, 16'h0100);
    wr(3'h1, 16'h8300);
    cyc(5);
    chk(16'(pin_oe_n[1]), 16'h0001);
    strobe(0);
    cyc(3);
    chk(16'(pin_oe_n[1]), 16'h0000);
    wr(3'h1, 16'h0300);
    $display("test sync done");
  endtask

  task automatic t_dead;
    wr(3'h3, 16'h0200);
    for (int n = 2; n <= 6; n += 4) begin
      wr(3'h2, 16'(n));
      cyc(80);
      chk(16'(pad[1:0]), 16'h0002);
      pwm_raw <= 1'b1;
      c = 0;
      repeat (20) begin
        @(posedge clock);
        c += (pin_out[1:0] === 2'b00);
      end
      if (n == 2) g2 = c;
      else g6 = c;
      chk(16'(pad[1:0]), 16'h0001);
      pwm_raw <= 1'b0;
    end
    chk(16'(g2), 16'h0002);
    chk(16'(g6 - g2), 16'h0004);
    wr(3'h2, 16'h0000);
    $display("test dead time done");
  endtask

  task automatic t_trig;
    wr(3'h3, 16'hA000);
    wr(3'h1, 16'h0100);
    wr(3'h4, 16'h0003);
    cyc(3);
    chk(16'(tb_run), 16'h0000);
    chk(16'(pin_oe_n[0]), 16'h0001);
    strobe(1);
    cyc(3);
    chk(16'(tb_run), 16'h0001);
    chk(16'(pin_oe_n[0]), 16'h0000);
    strobe(0);
    strobe(0);
    cyc(2);
    chk(16'(tb_run), 16'h0001);
    strobe(0);
    cyc(2);
    chk(16'(tb_run), 16'h0000);
    wr(3'h4, 16'h0000);
    wr(3'h3, 16'h0000);
    $display("test trigger done");
  endtask

  task automatic t_cap;
    int sel [6] = '{0, 1, 2, 3, 5, 6};
    cyc(4);
    chk(16'(capture_disable_flag), 16'h0001);
    capsrc <= 7'h01;
    cnt(8, 1'b0, c);
    chk(16'(c), 16'h0000);
    capsrc <= 7'h00;
    wr(3'h0, 16'h1000);
    cyc(4);
    chk(16'(capture_disable_flag), 16'h0000);
    foreach (sel[i]) begin
      wr(3'h1, 16'h0100 | 16'(sel[i]));
      capsrc <= 7'(1 << sel[i]);
      cnt(8, 1'b0, c);
      chk(16'(c), 16'h0001);
      capsrc <= 7'h00;
    end
    capsrc <= 7'h01;
    cnt(8, 1'b0, c);
    chk(16'(c), 16'h0000);
    capsrc <= 7'h00;
    wr(3'h1, 16'h0180);
    wr(3'h0, 16'h0000);
    cyc(4);
    chk(16'(capture_disable_flag), 16'h0001);
    wr(3'h1, 16'h0140);
    wr(3'h0, 16'h1000);
    cyc(4);
    chk(16'(capture_disable_flag), 16'h0000);
    wr(3'h0, 16'h0000);
    wr(3'h4, 16'h0000);
    $display("test capture done");
  endtask

  task automatic t_aux;
    int s [4] = '{0, 1, 3, 3};
    int k [4] = '{0, 0, 2, 2};
    int e [4] = '{0, 1, 1, 0};
    for (int i = 0; i < 4; i++) begin
      wr(3'h1, 16'h0100 | 16'(s[i] << 3));
      timer_mode <= (i == 3);
      fork
        strobe(k[i]);
        cnt(8, 1'b1, c);
      join
      chk(16'(c), 16'(e[i]));
    end
    timer_mode <= 1'b0;
    wr(3'h1, 16'h0110);
    mode_aux <= 1'b1;
    cyc(4);
    cnt(4, 1'b1, c);
    chk(16'(c), 16'h0004);
    mode_aux <= 1'b0;
    $display("test aux done");
  endtask

  // brush, push-pull and scan patterns on all six steered pins
  task automatic t_modes;
    wr(3'h1, 16'h3F00);
    wr(3'h3, 16'h0500);
    pwm_raw <= 1'b1;
    cyc(4);
    chk(16'(pin_oe_n), 16'h0000);
    chk(16'(pin_out), 16'h0009);
    wr(3'h3, 16'h0400);
    cyc(4);
    chk(16'(pin_out), 16'h0006);
    wr(3'h3, 16'h0100);
    cyc(4);
    v = 16'(pin_out);
    strobe(0);
    cyc(3);
    chk(16'(pin_out[0] ^ pin_out[1]), 16'h0001);
    chk(16'(v[1:0] ^ pin_out[1:0]), 16'h0003);
    wr(3'h3, 16'h0600);
    cyc(4);
    v = 16'(pin_out);
    chk(16'($countones(v)), 16'h0001);
    strobe(0);
    cyc(3);
    chk(16'(pin_out), {10'h000, v[4:0], v[5]});
    pwm_raw <= 1'b0;
    wr(3'h3, 16'h0000);
    wr(3'h1, 16'h0100);
    $display("test modes done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {arst_n, reg_wr, reg_rd, tb_rollover, pwm_raw, mode_aux} = '0;
    {timer_mode, compare_event, trig_in, fault_input_one} = '0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    capsrc = 7'h00;
    xsrc = 3'h0;
    err_count = 0;
    tests_run = 0;
    cyc(20);
    arst_n <= 1'b1;
    t_regs();
    t_steer();
    t_shut();
    t_src();
    t_gate();
    t_sync();
    t_dead();
    t_trig();
    t_cap();
    t_aux();
    t_modes();
    conclude();
  end

  initial begin
    #(25 * 20000);
    err_count++;
    conclude();
  end
endmodule // ccpos_top_tb

`default_nettype wire

// *** design/ccpos_cfg.svh ***
// constants for the ccp output shutdown control block
`ifndef CCPOS_CFG_SVH
`define CCPOS_CFG_SVH
// register indices on the plain register port
`define CCPOS_IDX_SDG      3'h0
`define CCPOS_IDX_STEER    3'h1
`define CCPOS_IDX_DT       3'h2
`define CCPOS_IDX_OMP      3'h3
`define CCPOS_IDX_STAT     3'h4
// reset values
`define CCPOS_RST_SDG      16'h0000
`define CCPOS_RST_STEER    16'h0100
`define CCPOS_RST_DT       16'h0000
`define CCPOS_RST_OMP      16'h0000
// implemented bits of each register
`define CCPOS_MASK_SDG     16'hD0FF
`define CCPOS_MASK_STEER   16'hBFDF
`define CCPOS_MASK_DT      16'h003F
`define CCPOS_MASK_OMP     16'hF73F
// bits that exist in the multi-output variant only
`define CCPOS_MULTI_STEER  16'h3E00
`define CCPOS_MULTI_DT     16'h003F
`define CCPOS_MULTI_OMP    16'h0713
// field positions
`define CCPOS_RESTART_BIT  15
`define CCPOS_GATEMODE_BIT 14
`define CCPOS_SWSHUT_BIT   12
`define CCPOS_STSYNC_BIT   15
`define CCPOS_OUTPUT_ON_TRIGGER_BIT   15
`define CCPOS_POLA_BIT     5
`define CCPOS_POLB_BIT     4
`define CCPOS_SHUTFLG_BIT  4
`define CCPOS_CAPDIS_BIT   2
`define CCPOS_TRIGGERED_MODE_ENABLE_BIT   2
`define CCPOS_SINGLE_TRIGGER_ENABLE_BIT  1
`endif

// *** design/ccpos_pkg.sv ***
// types for the ccp output shutdown control block
`default_nettype none
package ccpos_pkg;
  // trigger state of the time base, gray along hold -> run
  typedef enum logic [1:0] {
    CCPOS_TRG_HOLD = 2'h0,
    CCPOS_TRG_RUN  = 2'h1
  } ccpos_trg_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] sdg;
    logic [15:0] steer_reg;
    logic [15:0] dt_reg;
    logic [15:0] omp;
    logic [1:0]  trig_ctl;
    logic [9:0]  sync1;
    logic [9:0]  sync2;
    logic        shut;
    logic        capdis;
    logic [5:0]  steer;
    ccpos_trg_t  trg;
    logic [2:0]  os_cnt;
    logic [5:0]  dt_cnt;
    logic        pwm_prev;
    logic        gate_prev;
    logic        cap_prev;
    logic        phase;
    logic [2:0]  scan;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe_n;
    logic        aux_out;
    logic        cap_evt;
    logic        tb_run;
    logic [15:0] rdata;
  } ccpos_state_t;
endpackage : ccpos_pkg

`default_nettype wire

// *** design/ccpos_top.sv ***
// ccp output stage: shutdown, gating, steering, dead time, trigger and pin control
//
// Contract
// - auto restart clears shutdown at period start
// - gate mode delays shutdown to rollover
// - software shutdown acts like hardware source
// - eight enables admit eight shutdown sources
// - steer sync applies steering at rollover
// - pin driven only when steered
// - capture gating level, rise or fall modes
// - auxiliary output selects event source
// - capture source select picks capture input
// - dead time inserts N cycles gap
// - outputs held off until triggered
// - one-shot lasts K plus one periods
// - output mode selects pin pattern
// - group polarity bits invert pin groups
// - shutdown state drives active, inactive, float
// - some fields exist in multi variant
// - unimplemented bits read zero
// - shutdown flag shows shutdown in progress
// - triggered mode holds time base
// - one-shot duration from count field
// - capture disable flag blocks captures
//
// Decided for this implementation: the plain strobed port and the register addresses.
`include "ccpos_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ccpos_top #(
  parameter bit MULTI_OUT = 1'b1
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // time base side, same clock
  input  wire logic        tb_rollover,
  input  wire logic        pwm_raw,
  input  wire logic        mode_aux,
  input  wire logic        timer_mode,
  input  wire logic        compare_event,
  input  wire logic        trig_in,
  // asynchronous sources
  input  wire logic [2:0]  comparator_out,
  input  wire logic [1:0]  other_compare,
  input  wire logic        logic_cell_one,
  input  wire logic        logic_cell_two,
  input  wire logic        fault_input_one,
  input  wire logic        fault_input_two,
  input  wire logic        capture_pin,
  // outputs
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe_n,
  output logic             aux_out,
  output logic             capture_event,
  output logic             tb_run,
  output logic             shutdown_active_flag,
  output logic             capture_disable_flag
);

  ccpos_pkg::ccpos_state_t q;
  ccpos_pkg::ccpos_state_t d;

  // ****************************************
  // decoded fields
  // ****************************************
  logic [9:0]  async_in;
  logic [7:0]  shutdown_source_enables;
  logic        auto_restart_enable;
  logic        shutdown_gate_mode;
  logic        software_shutdown_force;
  logic        steer_update_sync;
  logic [1:0]  capture_gate_mode;
  logic [1:0]  aux_event_select;
  logic [2:0]  capture_input_select;
  logic [5:0]  dead_time_count;
  logic        output_on_trigger;
  logic [2:0]  one_shot_extend;
  logic [2:0]  output_mode_select;
  logic        polarity_group_a;
  logic        polarity_group_b;
  logic [1:0]  shutdown_state_group_a;
  logic [1:0]  shutdown_state_group_b;
  logic        triggered_mode_enable;
  logic        single_trigger_enable;
  logic        shut_req;
  logic        wr_stat;

  assign async_in = {capture_pin, logic_cell_two, fault_input_two, fault_input_one,
                     logic_cell_one, other_compare, comparator_out};
  assign shutdown_source_enables = q.sdg[7:0];
  assign auto_restart_enable     = q.sdg[`CCPOS_RESTART_BIT];
  assign shutdown_gate_mode      = q.sdg[`CCPOS_GATEMODE_BIT];
  assign software_shutdown_force = q.sdg[`CCPOS_SWSHUT_BIT];
  assign steer_update_sync       = q.steer_reg[`CCPOS_STSYNC_BIT];
  assign capture_gate_mode       = q.steer_reg[7:6];
  assign aux_event_select        = q.steer_reg[4:3];
  assign capture_input_select    = q.steer_reg[2:0];
  assign dead_time_count         = q.dt_reg[5:0];
  assign output_on_trigger       = q.omp[`CCPOS_OUTPUT_ON_TRIGGER_BIT];
  assign one_shot_extend         = q.omp[14:12];
  assign output_mode_select      = q.omp[10:8];
  assign polarity_group_a        = q.omp[`CCPOS_POLA_BIT];
  assign polarity_group_b        = q.omp[`CCPOS_POLB_BIT];
  assign shutdown_state_group_a  = q.omp[3:2];
  assign shutdown_state_group_b  = q.omp[1:0];
  assign triggered_mode_enable   = q.trig_ctl[`CCPOS_TRIGGERED_MODE_ENABLE_BIT - 1];
  assign single_trigger_enable   = q.trig_ctl[`CCPOS_SINGLE_TRIGGER_ENABLE_BIT - 1];
  assign wr_stat = reg_wr && (reg_addr == `CCPOS_IDX_STAT);

  // per-source enables, software force joins them
  assign shut_req = (|(q.sync2[7:0] & shutdown_source_enables)) | software_shutdown_force;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic [15:0] wmask;
    logic        cap_src;
    logic        a_act;
    logic        b_act;
    logic        drive_ok;
    logic        hold_off;
    logic [5:0]  act;
    logic [5:0]  lvl;
    logic [5:0]  oen;
    logic        pol;
    logic [1:0]  pss;
    wmask    = 16'h0000;
    cap_src  = 1'b0;
    a_act    = 1'b0;
    b_act    = 1'b0;
    drive_ok = 1'b0;
    hold_off = 1'b0;
    act      = 6'h00;
    lvl      = 6'h00;
    oen      = 6'h3F;
    pol      = 1'b0;
    pss      = 2'h0;
    d        = q;

    // input synchronisers
    d.sync1 = async_in;
    d.sync2 = q.sync1;

    // register writes
    // masked writes
    if (reg_wr) begin
      case (reg_addr)
        `CCPOS_IDX_SDG: d.sdg = reg_wdata & `CCPOS_MASK_SDG;
        `CCPOS_IDX_STEER: begin
          wmask = MULTI_OUT ? `CCPOS_MASK_STEER : (`CCPOS_MASK_STEER & ~`CCPOS_MULTI_STEER);
          d.steer_reg = reg_wdata & wmask;
        end
        `CCPOS_IDX_DT: begin
          wmask = MULTI_OUT ? `CCPOS_MASK_DT : (`CCPOS_MASK_DT & ~`CCPOS_MULTI_DT);
          d.dt_reg = reg_wdata & wmask;
        end
        `CCPOS_IDX_OMP: begin
          wmask = MULTI_OUT ? `CCPOS_MASK_OMP : (`CCPOS_MASK_OMP & ~`CCPOS_MULTI_OMP);
          d.omp = reg_wdata & wmask;
        end
        `CCPOS_IDX_STAT: d.trig_ctl = reg_wdata[1:0];
        default: d.sdg = q.sdg;
      endcase
    end

    // read data, one cycle after the strobe
    d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `CCPOS_IDX_SDG:   d.rdata = q.sdg;
        `CCPOS_IDX_STEER: d.rdata = q.steer_reg;
        `CCPOS_IDX_DT:    d.rdata = q.dt_reg;
        `CCPOS_IDX_OMP:   d.rdata = q.omp;
        `CCPOS_IDX_STAT: begin
          d.rdata[`CCPOS_SHUTFLG_BIT] = q.shut;
          d.rdata[`CCPOS_CAPDIS_BIT + 6] = q.trg == ccpos_pkg::CCPOS_TRG_RUN;
          d.rdata[`CCPOS_CAPDIS_BIT] = q.capdis;
          d.rdata[1:0] = q.trig_ctl;
        end
        default: d.rdata = 16'h0000;
      endcase
    end

    // shutdown flag: software write of 0 clears, set wins
    // auto restart
    if (wr_stat && !reg_wdata[`CCPOS_SHUTFLG_BIT]) d.shut = 1'b0;
    if (auto_restart_enable && !shut_req && tb_rollover) d.shut = 1'b0;
    if (shut_req && (!shutdown_gate_mode || tb_rollover)) d.shut = 1'b1;

    if (!steer_update_sync || tb_rollover) d.steer = q.steer_reg[13:8];

    // capture gating by the combined request
    d.gate_prev = shut_req;
    case (capture_gate_mode)
      2'h0: d.capdis = !shut_req;
      2'h1: if (shut_req && !q.gate_prev) d.capdis = 1'b0;
      2'h2: if (!shut_req && q.gate_prev) d.capdis = 1'b1;
      default: d.capdis = q.capdis;
    endcase

    case (capture_input_select)
      3'h0: cap_src = q.sync2[9];
      3'h1: cap_src = q.sync2[0];
      3'h2: cap_src = q.sync2[1];
      3'h3: cap_src = q.sync2[2];
      3'h5: cap_src = q.sync2[5];
      3'h6: cap_src = q.sync2[8];
      default: cap_src = 1'b0;
    endcase
    d.cap_prev = cap_src;
    d.cap_evt = cap_src && !q.cap_prev && !q.capdis;

    case (aux_event_select)
      2'h1: d.aux_out = tb_rollover;
      2'h2: d.aux_out = mode_aux;
      2'h3: d.aux_out = (q.cap_evt || compare_event) && !timer_mode;
      default: d.aux_out = 1'b0;
    endcase

    case (q.trg)
      ccpos_pkg::CCPOS_TRG_HOLD: begin
        if (trig_in) begin
          d.trg    = ccpos_pkg::CCPOS_TRG_RUN;
          d.os_cnt = one_shot_extend;
        end
      end
      ccpos_pkg::CCPOS_TRG_RUN: begin
        if (single_trigger_enable && tb_rollover) begin
          if (q.os_cnt == 3'h0) d.trg = ccpos_pkg::CCPOS_TRG_HOLD;
          else d.os_cnt = q.os_cnt - 3'h1;
        end
      end
      default: d.trg = ccpos_pkg::CCPOS_TRG_HOLD;
    endcase
    if (!triggered_mode_enable) d.trg = ccpos_pkg::CCPOS_TRG_HOLD;
    d.tb_run = !triggered_mode_enable || (d.trg == ccpos_pkg::CCPOS_TRG_RUN);

    d.pwm_prev = pwm_raw;
    if (pwm_raw != q.pwm_prev) d.dt_cnt = dead_time_count;
    else if (q.dt_cnt != 6'h00) d.dt_cnt = q.dt_cnt - 6'h01;
    a_act = q.pwm_prev && (q.dt_cnt == 6'h00);
    b_act = !q.pwm_prev && (q.dt_cnt == 6'h00);

    // period phase and scan position
    if (tb_rollover) begin
      d.phase = !q.phase;
      d.scan  = (q.scan == 3'h5) ? 3'h0 : q.scan + 3'h1;
    end

    case (MULTI_OUT ? output_mode_select : 3'h0)
      3'h0: act = {6{q.pwm_prev}};
      3'h1: act = {4'h0, q.pwm_prev && !q.phase, q.pwm_prev && q.phase};
      3'h2: act = {4'h0, b_act, a_act};
      3'h4: act = {2'h0, 1'b0, 1'b1, q.pwm_prev, 1'b0};
      3'h5: act = {2'h0, q.pwm_prev, 1'b0, 1'b0, 1'b1};
      3'h6: act = {5'h00, q.pwm_prev} << q.scan;
      default: act = 6'h00;
    endcase

    hold_off = output_on_trigger && triggered_mode_enable &&
               (q.trg != ccpos_pkg::CCPOS_TRG_RUN);

    // per pin level and enable
    for (int i = 0; i < 6; i++) begin
      pol = (i % 2 == 0) ? polarity_group_a : polarity_group_b;
      pss = (i % 2 == 0) ? shutdown_state_group_a : shutdown_state_group_b;
      drive_ok = q.steer[i] && !hold_off;
      lvl[i] = act[i] ^ pol;
      oen[i] = !drive_ok;
      if (q.shut) begin
        lvl[i] = pss[0] ^ pol;
        oen[i] = !drive_ok || !pss[1];
      end
    end
    d.pin_out  = lvl;
    d.pin_oe_n = oen;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q           <= '0;
      q.sdg       <= `CCPOS_RST_SDG;
      q.steer_reg <= `CCPOS_RST_STEER;
      q.dt_reg    <= `CCPOS_RST_DT;
      q.omp       <= `CCPOS_RST_OMP;
      q.steer     <= 6'h01;
      q.pin_oe_n  <= 6'h3F;
      q.tb_run    <= 1'b1;
      q.trg       <= ccpos_pkg::CCPOS_TRG_HOLD;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata            = q.rdata;
  assign pin_out              = q.pin_out;
  assign pin_oe_n             = q.pin_oe_n;
  assign aux_out              = q.aux_out;
  assign capture_event        = q.cap_evt;
  assign tb_run               = q.tb_run;
  assign shutdown_active_flag = q.shut;
  assign capture_disable_flag = q.capdis;

  // ****************************************
  // assertions
  // ****************************************
  property p_shut_now;
    @(posedge clock) disable iff (!arst_n)
      shut_req && !shutdown_gate_mode |=> shutdown_active_flag;
  endproperty
  a_shut_now: assert property (p_shut_now) else $error("immediate shutdown missed");

  property p_shut_wait;
    @(posedge clock) disable iff (!arst_n)
      shutdown_gate_mode && !tb_rollover && !q.shut |=> !shutdown_active_flag;
  endproperty
  a_shut_wait: assert property (p_shut_wait) else $error("gated shutdown too early");

  property p_restart;
    @(posedge clock) disable iff (!arst_n)
      q.shut && auto_restart_enable && !shut_req && tb_rollover |=> !shutdown_active_flag;
  endproperty
  a_restart: assert property (p_restart) else $error("auto restart missed");

  property p_no_restart;
    @(posedge clock) disable iff (!arst_n)
      q.shut && !auto_restart_enable && !wr_stat |=> shutdown_active_flag;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("shutdown left by itself");

  property p_float;
    @(posedge clock) disable iff (!arst_n)
      q.shut && !shutdown_state_group_a[1] |=> pin_oe_n[0];
  endproperty
  a_float: assert property (p_float) else $error("pin a not floated");

  property p_steer_off;
    @(posedge clock) disable iff (!arst_n)
      !q.steer[0] |=> pin_oe_n[0];
  endproperty
  a_steer_off: assert property (p_steer_off) else $error("unsteered pin driven");

  property p_steer_sync;
    @(posedge clock) disable iff (!arst_n)
      steer_update_sync && !tb_rollover |=> q.steer == $past(q.steer);
  endproperty
  a_steer_sync: assert property (p_steer_sync) else $error("steering changed early");

  property p_cap_fall;
    @(posedge clock) disable iff (!arst_n)
      capture_gate_mode == 2'h2 && q.gate_prev && !shut_req |=> capture_disable_flag;
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("falling gate kept captures");

  property p_aux_roll;
    @(posedge clock) disable iff (!arst_n)
      aux_event_select == 2'h1 |=> aux_out == $past(tb_rollover);
  endproperty
  a_aux_roll: assert property (p_aux_roll) else $error("aux rollover mismatch");

  property p_trig_hold;
    @(posedge clock) disable iff (!arst_n)
      triggered_mode_enable && q.trg == ccpos_pkg::CCPOS_TRG_HOLD && !trig_in |=> !tb_run;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("time base ran untriggered");

endmodule : ccpos_top

`default_nettype wire
